// ---- hdl/splr_top.sv ----
// Speed-loop PI regulator with winder feedback scaling and underwind inversion.
// Assumes config, writes and signal inputs come from logic on mclk; feedback is lead/lag output.
`timescale 1ns/100ps
`default_nettype none
module splr_top #(
  parameter int SCAN_5MS  = splr_pkg::SCAN_5MS_CYC,
  parameter int SCAN_10MS = splr_pkg::SCAN_10MS_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire splr_pkg::splr_wr_s  net_wr,
  input  wire splr_pkg::splr_cfg_s cfg,
  input  wire logic signed [15:0] speed_ref,
  input  wire logic signed [15:0] speed_feedback,
  input  wire logic signed [15:0] analog_trim_ref,
  input  wire logic signed [15:0] limit_block_in,
  output logic signed [15:0]    regulator_out,
  output logic signed [15:0]    scaled_feedback,
  output logic signed [15:0]    limit_block_out,
  output logic [15:0]           control_word_rd,
  output logic [15:0]           feedback_gain_rd,
  output logic [15:0]           initial_value_rd,
  output logic                  scan_tick
);
  // The tick counter is 24 bits wide, so longer scan periods cannot be served.
  if ((SCAN_5MS < 2) || (SCAN_10MS < 2) || (SCAN_5MS > 32'h00ffffff) || (SCAN_10MS > 32'h00ffffff)) begin : g_bad_scan
    $error("scan counts outside what the tick counter can serve");
  end

  //////////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire logic rst_n = rst_sync_r;

  //////////////////////////////////////////////////////////////////////////////
  // Scan tick generator.
  logic [23:0] scan_cnt_r;
  logic [23:0] scan_cnt_nxt;
  logic [23:0] scan_len;
  always_comb begin
    scan_len     = cfg.scan_10ms ? 24'(SCAN_10MS - 1) : 24'(SCAN_5MS - 1);
    scan_tick    = (scan_cnt_r >= scan_len);
    scan_cnt_nxt = scan_tick ? 24'h000000 : scan_cnt_r + 24'h000001;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt_r <= 24'h000000;
    end else begin
      scan_cnt_r <= scan_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Network write decode. Writes count only in the alternate map under network control;
  // anything else on the write port is dropped silently.
  logic        alt_map;
  logic        wr_ctrl;
  logic        wr_gain;
  logic        wr_init;
  logic        net_left;
  logic        net_prev_r;
  logic        net_prev_nxt;
  always_comb begin
    alt_map      = cfg.network_src && (cfg.map_choice == splr_pkg::MAP_ALTERNATE);
    wr_ctrl      = net_wr.wr && alt_map && (net_wr.idx == splr_pkg::REG_CONTROL_WORD);
    wr_gain      = net_wr.wr && alt_map && (net_wr.idx == splr_pkg::REG_FEEDBACK_GAIN);
    wr_init      = net_wr.wr && alt_map && (net_wr.idx == splr_pkg::REG_INITIAL_VALUE);
    net_left     = net_prev_r && !cfg.network_src;
    net_prev_nxt = cfg.network_src;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      net_prev_r <= 1'b0;
    end else begin
      net_prev_r <= net_prev_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Winder control word. A write needs network control, so it can never meet the
  // underwind clear, which fires only on the cycle network control is lost.
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = net_wr.data;
    end
    if (net_left) begin
      ctrl_nxt[splr_pkg::UNDERWIND_BIT] = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= splr_pkg::CONTROL_WORD_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Feedback gain. Out-of-span writes are clamped rather than refused, so the multiplier
  // never sees less than unity or more than thirty-two.
  logic [15:0] gain_r;
  logic [15:0] gain_nxt;
  logic [15:0] wclamp;
  always_comb begin
    wclamp = net_wr.data;
    if (wclamp < splr_pkg::GAIN_UNITY) begin
      wclamp = splr_pkg::GAIN_UNITY;
    end else if (wclamp > splr_pkg::GAIN_MAX) begin
      wclamp = splr_pkg::GAIN_MAX;
    end
    gain_nxt = gain_r;
    if (wr_gain) begin
      gain_nxt = wclamp;
    end
    if (cfg.network_src && (cfg.map_choice != splr_pkg::MAP_ALTERNATE)) begin
      gain_nxt = splr_pkg::GAIN_UNITY;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gain_r <= splr_pkg::GAIN_UNITY;
    end else begin
      gain_r <= gain_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Network initial value.
  logic [15:0] init_r;
  logic [15:0] init_nxt;
  always_comb begin
    init_nxt = init_r;
    if (wr_init) begin
      init_nxt = net_wr.data;
    end
    if (!cfg.network_src) begin
      init_nxt = splr_pkg::INITIAL_RESET;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_r <= splr_pkg::INITIAL_RESET;
    end else begin
      init_r <= init_nxt;
    end
  end
  assign control_word_rd  = ctrl_r;
  assign feedback_gain_rd = gain_r;
  assign initial_value_rd = init_r;

  //////////////////////////////////////////////////////////////////////////////
  // Operand selection. Lead frequency and proportional gain outside their span are clamped rather than refused, so a
  // stray setting cannot push the regulator beyond what the loop was tuned for.
  logic [1:0]         src_sel;
  logic               hold;
  logic signed [15:0] init_val;
  logic               underwind;
  logic [15:0]        lead;
  logic [15:0]        lead_max;
  logic [15:0]        kp;
  logic [7:0]         scans_per_s;
  always_comb begin
    src_sel   = cfg.network_src ? cfg.init_source_select : splr_pkg::SRC_ZERO;
    hold      = (cfg.network_src && cfg.hold_reset) || !cfg.drive_running;
    underwind = alt_map && ctrl_r[splr_pkg::UNDERWIND_BIT];
    case (src_sel)
      splr_pkg::SRC_NETWORK: init_val = $signed(init_r);
      splr_pkg::SRC_ANALOG:  init_val = analog_trim_ref;
      default:               init_val = 16'sh0000;
    endcase
    if (cfg.armature_fb && cfg.scan_10ms) begin
      lead_max = splr_pkg::LEAD_MAX_ARM_10MS;
    end else begin
      lead_max = splr_pkg::LEAD_MAX_OTHER;
    end
    lead = cfg.lead_freq;
    if (lead > lead_max) begin
      lead = lead_max;
    end
    kp = cfg.prop_gain;
    if (kp < splr_pkg::PGAIN_MIN) begin
      kp = splr_pkg::PGAIN_MIN;
    end else if (kp > splr_pkg::PGAIN_MAX) begin
      kp = splr_pkg::PGAIN_MAX;
    end
    if (cfg.scan_10ms) begin
      scans_per_s = 8'(splr_pkg::SCAN_10MS_PER_S);
    end else begin
      scans_per_s = 8'(splr_pkg::SCAN_5MS_PER_S);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Feedback path. The scaled value saturates at 16 bits: a gain of thirty-two on a large
  // feedback would otherwise wrap and reverse the loop.
  logic signed [33:0] prod;
  logic signed [33:0] fbs;
  logic signed [15:0] fb_r;
  logic signed [15:0] fb_nxt;
  logic signed [15:0] lim_r;
  logic signed [15:0] lim_nxt;
  always_comb begin
    prod = speed_feedback * $signed({1'b0, gain_r});
    if (cfg.network_src) begin
      fbs = prod / 34'sd1000;
    end else begin
      fbs = 34'(speed_feedback);
    end
    if (fbs > 34'sd32767) begin
      fbs = 34'sd32767;
    end else if (fbs < -34'sd32768) begin
      fbs = -34'sd32768;
    end
    fb_nxt  = fb_r;
    lim_nxt = lim_r;
    if (scan_tick) begin
      fb_nxt  = underwind ? -fbs[15:0] : fbs[15:0];
      lim_nxt = underwind ? -limit_block_in : limit_block_in;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fb_r  <= 16'sh0000;
      lim_r <= 16'sh0000;
    end else begin
      fb_r  <= fb_nxt;
      lim_r <= lim_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Regulator. The error uses the previous tick's scaled feedback, one scan of delay in the
  // loop. The integral keeps 48 bits but is clamped to the 16-bit range and holds no fraction, so small increments truncate to zero.
  logic signed [16:0] err;
  logic signed [33:0] pterm;
  logic signed [47:0] iprod;
  logic signed [47:0] idiv;
  logic signed [47:0] iinc;
  logic signed [47:0] total;
  logic signed [47:0] integ_r;
  logic signed [47:0] integ_nxt;
  logic signed [15:0] out_r;
  logic signed [15:0] out_nxt;
  always_comb begin
    err   = 17'(speed_ref) - 17'(fb_r);
    pterm = (err * $signed({1'b0, kp})) / 34'sd100;
    iprod = 48'(pterm) * $signed({1'b0, lead});
    idiv  = $signed({8'h00, 40'd100 * 40'(scans_per_s)});
    iinc  = 48'sh0;
    if (lead != 16'h0000) begin
      iinc = iprod / idiv;
    end
    total     = 48'sh0;
    integ_nxt = integ_r;
    out_nxt   = out_r;
    if (scan_tick) begin
      if (hold) begin
        integ_nxt = 48'(init_val);
        out_nxt   = init_val;
      end else begin
        if (lead == 16'h0000) begin
          integ_nxt = 48'sh0;
        end else begin
          integ_nxt = integ_r + iinc;
        end
        if (integ_nxt > 48'sd32767) begin
          integ_nxt = 48'sd32767;
        end else if (integ_nxt < -48'sd32768) begin
          integ_nxt = -48'sd32768;
        end
        total = integ_nxt + 48'(pterm);
        if (total > 48'sd32767) begin
          out_nxt = 16'sh7fff;
        end else if (total < -48'sd32768) begin
          out_nxt = 16'sh8000;
        end else begin
          out_nxt = total[15:0];
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      integ_r <= 48'sh0;
      out_r   <= 16'sh0000;
    end else begin
      integ_r <= integ_nxt;
      out_r   <= out_nxt;
    end
  end

  assign regulator_out   = out_r;
  assign scaled_feedback = fb_r;
  assign limit_block_out = lim_r;
endmodule : splr_top
`default_nettype wire

// ---- hdl/splr_pkg.sv ----
// Constants, register map and carrier types of the speed-loop regulator.
// Assumes a network master writes 16-bit words by register index through a simple write port.
//
// How it works
// - Initial value source: 0 zero, 1 network value, 2 analog trim; default 0.
// - Source selector reads as zero unless control source is network.
// - Network initial value is signed 16-bit, default 0, forced 0 off network.
// - Lead frequency limit 282.74 with armature/10 ms, else 327.67; default 3.00.
// - Lead frequency of zero drops the integral term: proportional only.
// - Proportional gain 0.10 to 128.00 in hundredths, default 4.40.
// - Network reset flag 1 holds regulator at initial value; default 0.
// - Reset flag forced off unless control source is network.
// - Speed feedback multiplied by gain value and divided by 1000.
// - Gain value spans 1000 to 32000, default 1000 meaning unity.
// - Original register map forces the gain value to 1000.
// - Off network the gain multiplier is bypassed.
// - Control word bit 5 inverts speed feedback and current limit input.
// - Leaving network control clears the underwind bit.
// - Winding features act only on network with map selector 2.
// - Alternate map takes gain operand from register 38.
// - Alternate map takes initial value from register 39.
// - Regulator also held at initial value while the drive is stopped.
// - Regulator is gain times (s plus lead) over s on speed error.
package splr_pkg;
  localparam logic [5:0]  REG_CONTROL_WORD   = 6'h20;
  localparam logic [5:0]  REG_FEEDBACK_GAIN  = 6'h26;
  localparam logic [5:0]  REG_INITIAL_VALUE  = 6'h27;
  localparam int          UNDERWIND_BIT      = 5;
  localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;
  localparam logic [15:0] GAIN_UNITY         = 16'h03e8;
  localparam logic [15:0] GAIN_MAX           = 16'h7d00;
  localparam logic [15:0] INITIAL_RESET      = 16'h0000;
  localparam logic [15:0] LEAD_MAX_ARM_10MS  = 16'h6e72;
  localparam logic [15:0] LEAD_MAX_OTHER     = 16'h7fff;
  localparam logic [15:0] LEAD_DEFAULT       = 16'h012c;
  localparam logic [15:0] PGAIN_MIN          = 16'h000a;
  localparam logic [15:0] PGAIN_MAX          = 16'h3200;
  localparam logic [15:0] PGAIN_DEFAULT      = 16'h01b8;
  localparam logic [1:0]  SRC_ZERO           = 2'h0;
  localparam logic [1:0]  SRC_NETWORK        = 2'h1;
  localparam logic [1:0]  SRC_ANALOG         = 2'h2;
  localparam logic [1:0]  MAP_ALTERNATE      = 2'h2;
  localparam int          SCAN_5MS_NS        = 5000000;
  localparam int          SCAN_10MS_NS       = 10000000;
  localparam int          CLK_NS             = 4;
  localparam int          SCAN_5MS_CYC       = SCAN_5MS_NS / CLK_NS;
  localparam int          SCAN_10MS_CYC      = SCAN_10MS_NS / CLK_NS;
  localparam int          SCAN_5MS_PER_S     = 200;
  localparam int          SCAN_10MS_PER_S    = 100;

  typedef struct packed {
    logic        wr;
    logic [5:0]  idx;
    logic [15:0] data;
  } splr_wr_s;

  typedef struct packed {
    logic        network_src;
    logic [1:0]  map_choice;
    logic        drive_running;
    logic        armature_fb;
    logic        scan_10ms;
    logic [1:0]  init_source_select;
    logic        hold_reset;
    logic [15:0] lead_freq;
    logic [15:0] prop_gain;
  } splr_cfg_s;
endpackage : splr_pkg

// ---- verif/splr_checker.sv ----
// Port assertions for the speed-loop regulator.
// Assumes binding onto splr_top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module splr_checker #(
  parameter int SCAN_5MS  = 20,
  parameter int SCAN_10MS = 40
) (
  input wire logic                mclk,
  input wire logic                rstn,
  input wire splr_pkg::splr_wr_s  net_wr,
  input wire splr_pkg::splr_cfg_s cfg,
  input wire logic signed [15:0]  speed_ref,
  input wire logic signed [15:0]  speed_feedback,
  input wire logic signed [15:0]  analog_trim_ref,
  input wire logic signed [15:0]  limit_block_in,
  input wire logic signed [15:0]  regulator_out,
  input wire logic signed [15:0]  scaled_feedback,
  input wire logic signed [15:0]  limit_block_out,
  input wire logic [15:0]         control_word_rd,
  input wire logic [15:0]         feedback_gain_rd,
  input wire logic [15:0]         initial_value_rd,
  input wire logic                scan_tick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic alt;
  logic uw;
  assign alt = cfg.network_src && cfg.map_choice == splr_pkg::MAP_ALTERNATE;
  assign uw  = alt && control_word_rd[5];
  chk_gain_unity: assert property (cfg.network_src && !alt |=> feedback_gain_rd == 16'h03e8)
    else $error("gain not unity in original map");
  chk_gain_write: assert property (alt && net_wr.wr && net_wr.idx == 6'h26 && net_wr.data >= 16'h03e8
    && net_wr.data <= 16'h7d00 |=> feedback_gain_rd == $past(net_wr.data)) else $error("gain write lost");
  chk_init_write: assert property (alt && net_wr.wr && net_wr.idx == 6'h27 |=> initial_value_rd == $past(net_wr.data))
    else $error("initial value write lost");
  chk_off_net: assert property (!cfg.network_src |=> initial_value_rd == 16'h0000 && !control_word_rd[5])
    else $error("network values kept off network");
  chk_fb_bypass: assert property (scan_tick && !cfg.network_src |=> scaled_feedback == $past(speed_feedback))
    else $error("feedback scaled off network");
  chk_limit_pass: assert property (scan_tick && !uw |=> limit_block_out == $past(limit_block_in))
    else $error("limit input altered");
  chk_limit_inv: assert property (scan_tick && uw |=> limit_block_out == -$past(limit_block_in))
    else $error("limit input not inverted");
  chk_stop_zero: assert property (scan_tick && !cfg.drive_running && !cfg.network_src |=> regulator_out == 0)
    else $error("stopped output not zero");
  chk_tick_gap: assert property (scan_tick |=> !scan_tick [*8])
    else $error("scan ticks too close");
  cover property (scan_tick && uw);
  cover property (alt && net_wr.wr);
  cover property (scan_tick && !cfg.drive_running);
endmodule // splr_checker
bind splr_top splr_checker #(.SCAN_5MS(SCAN_5MS), .SCAN_10MS(SCAN_10MS)) i_chk (.mclk(mclk), .rstn(rstn),
  .net_wr(net_wr), .cfg(cfg), .speed_ref(speed_ref), .speed_feedback(speed_feedback),
  .analog_trim_ref(analog_trim_ref), .limit_block_in(limit_block_in), .regulator_out(regulator_out),
  .scaled_feedback(scaled_feedback), .limit_block_out(limit_block_out), .control_word_rd(control_word_rd),
  .feedback_gain_rd(feedback_gain_rd), .initial_value_rd(initial_value_rd), .scan_tick(scan_tick));
`default_nettype wire

// ---- verif/splr_master.sv ----
// Network master model writing single register words.
// Assumes the bench calls put from its main sequence.
`timescale 1ns/100ps
`default_nettype none
module splr_master (
  input  wire logic               mclk,
  output var  splr_pkg::splr_wr_s net_wr
);
  initial net_wr = '0;
  // One word every two edges; the strobe drops an edge later, so calls never clash.
  task automatic put(input logic [5:0] idx, input logic [15:0] data);
    @(posedge mclk);
    net_wr <= '{1'b1, idx, data};
    @(posedge mclk);
    net_wr.wr <= 1'b0;
  endtask
endmodule // splr_master
`default_nettype wire

// ---- verif/speed_loop_pi_winder_control_bench.sv ----
// Self-checking bench for the speed-loop regulator.
// Assumes scan periods shortened to 20 and 40 cycles.
`timescale 1ns/100ps
`default_nettype none
module speed_loop_pi_winder_control_bench;
  logic                mclk = 1'b0;
  logic                rstn = 1'b0;
  splr_pkg::splr_wr_s  wr;
  splr_pkg::splr_cfg_s cfg;
  logic signed [15:0]  sref, fb, trim, lim, ro, sfb, lo;
  logic [15:0]         cw, gr, iv;
  logic                tick;
  int                  n_fail = 0, n_checks = 0, cyc = 0, k, g;
  int                  gl[3] = '{1000, 2000, 32000};
  always #2 mclk = ~mclk;
  splr_master i_net (.mclk(mclk), .net_wr(wr));
  splr_top #(.SCAN_5MS(20), .SCAN_10MS(40)) i_dut (.mclk(mclk), .rstn(rstn), .net_wr(wr), .cfg(cfg),
    .speed_ref(sref), .speed_feedback(fb), .analog_trim_ref(trim), .limit_block_in(lim), .regulator_out(ro),
    .scaled_feedback(sfb), .limit_block_out(lo), .control_word_rd(cw), .feedback_gain_rd(gr),
    .initial_value_rd(iv), .scan_tick(tick));
  function automatic logic [15:0] m_fb(input int f, input int gn, input bit inv);
    return 16'(inv ? -(f * gn / 1000) : f * gn / 1000);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Sample on the falling edge after the tick edge, clear of the update.
  task automatic tk();
    do @(negedge mclk); while (tick !== 1'b1);
    @(negedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      $display("FAIL timeout expected done seen hang");
      close_out();
    end
  end
  initial begin
    cfg = '{1'b1, 2'h2, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 16'h012c, 16'h01b8};
    {sref, fb, trim, lim} = '0;
    k = $urandom(76373);
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("cw_reset", 16'h0000, cw);
    chk("gain_reset", 16'h03e8, gr);
    chk("init_reset", 16'h0000, iv);
    for (int i = 0; i < 4; i++) begin
      g = (i < 3) ? gl[i] : 1000 * (1 + $urandom % 32);
      k = $urandom % 2001 - 1000;
      i_net.put(6'h20, 16'h0000);
      i_net.put(6'h26, 16'(g));
      @(posedge mclk);
      fb <= 16'(k);
      lim <= 16'(k);
      tk();
      chk("gain_rd", 16'(g), gr);
      chk("scaled_fb", m_fb(k, g, 0), sfb);
      chk("limit_out", 16'(k), lo);
    end
    $display("done gain");
    i_net.put(6'h20, 16'h0020);
    i_net.put(6'h26, 16'h07d0);
    tk();
    chk("cw_rd", 16'h0020, cw);
    chk("scaled_uw", m_fb(k, 2000, 1), sfb);
    chk("limit_uw", 16'(-k), lo);
    $display("done underwind");
    @(posedge mclk);
    cfg.map_choice <= 2'h1;
    i_net.put(6'h26, 16'h1388);
    tk();
    chk("gain_orig", 16'h03e8, gr);
    chk("scaled_orig", m_fb(k, 1000, 0), sfb);
    chk("limit_orig", 16'(k), lo);
    $display("done original map");
    @(posedge mclk);
    cfg.map_choice <= 2'h2;
    i_net.put(6'h20, 16'h0020);
    i_net.put(6'h26, 16'h0bb8);
    i_net.put(6'h27, 16'h1234);
    @(negedge mclk);
    chk("init_rd", 16'h1234, iv);
    @(posedge mclk);
    cfg.network_src <= 1'b0;
    tk();
    chk("uw_cleared", 16'h0000, {15'h0000, cw[5]});
    chk("init_forced", 16'h0000, iv);
    chk("scaled_off", 16'(k), sfb);
    chk("limit_off", 16'(k), lo);
    $display("done off network");
    @(posedge mclk);
    cfg.network_src <= 1'b1;
    cfg.hold_reset <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      k = $urandom % 65536;
      @(posedge mclk);
      trim <= 16'($urandom);
      cfg.init_source_select <= 2'(s);
      i_net.put(6'h27, 16'(k));
      tk();
      chk("hold_out", s == 0 ? 16'h0000 : (s == 1 ? 16'(k) : trim), ro);
    end
    @(posedge mclk);
    cfg.hold_reset <= 1'b0;
    cfg.drive_running <= 1'b0;
    tk();
    chk("stop_out", trim, ro);
    @(posedge mclk);
    cfg.network_src <= 1'b0;
    tk();
    chk("stop_off_net", 16'h0000, ro);
    $display("done hold");
    @(posedge mclk);
    cfg.network_src <= 1'b1;
    {cfg.armature_fb, cfg.scan_10ms} <= 2'h3;
    {cfg.drive_running, cfg.init_source_select} <= 3'h4;
    {cfg.lead_freq, cfg.prop_gain} <= {16'h0000, 16'h0064};
    {sref, fb} <= {16'sd1000, 16'sd200};
    i_net.put(6'h20, 16'h0000);
    i_net.put(6'h26, 16'h03e8);
    repeat (3) tk();
    chk("p_only", 16'h0320, ro);
    $display("done proportional");
    close_out();
  end
endmodule // speed_loop_pi_winder_control_bench
`default_nettype wire
